/* File: hdl/cond_regs_pkg.sv */
package cond_regs_pkg;

  // register offsets
  localparam logic [7:0] OFS_INTERFACE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DEVICE_STATUS = 8'h02;
  localparam logic [7:0] OFS_OPERATING_COMMAND = 8'h30;
  localparam logic [7:0] OFS_PROGRAM_TRIGGER = 8'h6a;
  // nonvolatile-backed window 0xa0..0xbf, indexed by the low five address bits
  localparam logic [2:0] NV_WINDOW_TAG = 3'b101;
  localparam int NV_DEPTH = 32;
  localparam logic [4:0] NV_IDX_SYS_CONFIG1 = 5'h01;
  localparam logic [4:0] NV_IDX_SYS_CONFIG2 = 5'h02;
  localparam logic [4:0] NV_IDX_LOCK = 5'h1f;

  // interface control field positions (each field mirrored)
  localparam int POS_SERIAL_OUT_HI = 7;
  localparam int POS_SERIAL_OUT_LO = 0;
  localparam int POS_LSB_FIRST_HI = 6;
  localparam int POS_LSB_FIRST_LO = 1;
  localparam int POS_CHIP_RESET_HI = 5;
  localparam int POS_CHIP_RESET_LO = 2;

  // status field positions
  localparam int POS_FAULT_CODE_LO = 3;
  localparam int POS_CHECKSUM_FAIL = 2;
  localparam int POS_LOAD_DONE = 1;

  // nonvolatile fields cleared while the checksum failure flag stands
  localparam int POS_ONE_WIRE_DUAL_PORT = 3;
  localparam int POS_ONE_WIRE_ENTRY_WINDOW = 2;
  localparam int POS_ONE_WIRE_DISABLE = 1;
  localparam int POS_REGULATOR_DISABLE = 7;
  localparam int POS_REFERENCE_BUFFER_DISABLE = 5;
  localparam int POS_NV_LOCK = 0;

  // reset values
  localparam logic RST_SERIAL_OUT_PIN_SELECT = 1'b1;
  localparam logic RST_LSB_FIRST = 1'b0;
  localparam logic RST_CHECKSUM_FAIL = 1'b0;
  localparam logic RST_LOAD_DONE = 1'b0;
  localparam logic [7:0] RST_OPERATING_COMMAND = 8'h03;
  localparam logic [7:0] RST_PROGRAM_TRIGGER = 8'h00;
  localparam logic [7:0] RST_NV_ENTRY = 8'h00;

  // command values
  localparam logic [7:0] CMD_COMMAND_MODE = 8'h00;
  localparam logic [7:0] CMD_ACTIVE_MODE = 8'h03;
  localparam logic [7:0] CMD_NV_PROGRAM_MODE = 8'h33;
  localparam logic [7:0] PROGRAM_START_VALUE = 8'h1e;

  // serial frame: command byte, address byte, data byte (write) or dummy+data (read)
  localparam int FRAME_CNT_W = 6;
  localparam logic [5:0] BIT_CMD_LAST = 6'h07;
  localparam logic [5:0] BIT_ADDR_LAST = 6'h0f;
  localparam logic [5:0] BIT_THIRD_LAST = 6'h17;
  localparam logic [5:0] BIT_FRAME_END = 6'h20;
  localparam int POS_CMD_READ = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } link_write_t;

  typedef struct packed {
    logic one_wire_disable;
    logic one_wire_dual_port;
    logic one_wire_entry_window;
    logic regulator_disable;
    logic reference_buffer_disable;
    logic nv_lock;
  } safety_cfg_t;

  typedef enum logic [2:0] {
    LD_START = 3'b001,
    LD_WAIT = 3'b010,
    LD_IDLE = 3'b100
  } load_state_t;

endpackage

/* File: hdl/serial_link_port.sv */
// link end of the register port, clocked by the host's serial clock
module serial_link_port
  import cond_regs_pkg::*;
(
  input wire logic sclk, // serial clock from host
  input wire logic nrst, // async reset, active low
  input wire logic cs_n, // chip select, active low
  input wire logic sdi, // serial data in, four-wire
  input wire logic sdio_i, // shared data pin, input side
  output logic sdio_o, // shared data pin, output side
  output logic sdio_oe_n, // shared data pin, low while driving
  output logic sdo_o, // separate serial data out
  output logic sdo_oe_n, // separate serial data out, low while driving
  input wire logic serial_out_pin_select, // level from register domain
  input wire logic lsb_first, // level from register domain
  output link_write_t wr_word, // write held stable after toggle
  output logic wr_tgl, // toggles once per write frame
  output logic [7:0] rd_addr, // read address held after toggle
  output logic rd_tgl, // toggles once per read request
  input wire logic [7:0] rd_data, // answer held stable by register domain
  input wire logic rd_ack_tgl // toggles when rd_data is valid
);

  logic [1:0] mode_sync;
  logic [1:0] order_sync;
  logic [1:0] ack_sync;
  logic [FRAME_CNT_W-1:0] cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txreg;
  logic is_read;
  logic in_bit;
  logic drive;

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      mode_sync <= {2{RST_SERIAL_OUT_PIN_SELECT}};
      order_sync <= {2{RST_LSB_FIRST}};
      ack_sync <= 2'b00;
    end else begin
      mode_sync <= {mode_sync[0], serial_out_pin_select};
      order_sync <= {order_sync[0], lsb_first};
      ack_sync <= {ack_sync[0], rd_ack_tgl};
    end
  end

  assign in_bit = mode_sync[1] ? sdi : sdio_i;
  assign next_shreg = order_sync[1] ? {in_bit, shreg[7:1]} : {shreg[6:0], in_bit};

  // frame state is cleared by the frame's own select, since sclk stops between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt <= '0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      txreg <= 8'h00;
    end else begin
      if (cnt != BIT_FRAME_END)
        cnt <= cnt + 6'd1;
      shreg <= next_shreg;
      if (cnt == BIT_CMD_LAST)
        is_read <= next_shreg[POS_CMD_READ];
      if (cnt == BIT_THIRD_LAST)
        txreg <= (ack_sync[1] == rd_tgl) ? rd_data : 8'h00;
      else if (order_sync[1])
        txreg <= {1'b0, txreg[7:1]};
      else
        txreg <= {txreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      wr_word <= '0;
      wr_tgl <= 1'b0;
      rd_addr <= 8'h00;
      rd_tgl <= 1'b0;
    end else if (!cs_n) begin
      if (cnt == BIT_ADDR_LAST && is_read) begin
        rd_addr <= next_shreg;
        rd_tgl <= ~rd_tgl;
      end
      if (cnt == BIT_ADDR_LAST)
        wr_word.addr <= next_shreg;
      if (cnt == BIT_THIRD_LAST && !is_read) begin
        wr_word.data <= next_shreg;
        wr_tgl <= ~wr_tgl;
      end
    end
  end

  assign drive = !cs_n && is_read && (cnt > BIT_THIRD_LAST) && (cnt != BIT_FRAME_END);
  assign sdo_o = order_sync[1] ? txreg[0] : txreg[7];
  assign sdio_o = sdo_o;
  assign sdo_oe_n = !(drive && mode_sync[1]);
  assign sdio_oe_n = !(drive && !mode_sync[1]);

endmodule

/* File: hdl/sensor_conditioner_regs.sv */
module sensor_conditioner_regs
  import cond_regs_pkg::*;
(
  input wire logic clock, // register domain clock
  input wire logic nrst, // async reset, active low
  input wire logic sclk, // serial clock from host
  input wire logic cs_n, // chip select, active low
  input wire logic sdi, // serial data in, four-wire
  input wire logic sdio_i, // shared data pin, input side
  output logic sdio_o, // shared data pin, output side
  output logic sdio_oe_n, // shared data pin, low while driving
  output logic sdo_o, // separate serial data out
  output logic sdo_oe_n, // separate serial data out, low while driving
  input wire logic [4:0] fault_code, // input fault levels from monitor
  output logic load_start, // pulse: begin nonvolatile load
  input wire logic ld_we, // loader writes one shadow entry
  input wire logic [4:0] ld_index, // loader entry index
  input wire logic [7:0] ld_data, // loader entry data
  input wire logic load_done, // pulse: load finished
  input wire logic load_crc_err, // with load_done: checksum mismatch
  output logic prog_start, // pulse: begin nonvolatile programming
  input wire logic prog_done, // pulse: programming finished
  output logic chip_reset, // pulse: whole-chip soft reset
  output logic [7:0] op_command, // operating command register
  output safety_cfg_t safety_cfg // effective safety configuration
);

  link_write_t wr_word;
  logic wr_tgl;
  logic [7:0] rd_addr;
  logic rd_tgl;
  logic [7:0] rd_data;
  logic rd_ack_tgl;
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [4:0] fault_meta;
  logic [4:0] fault_sync;
  logic wr_ev;
  logic rd_ev;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  logic serial_out_pin_select;
  logic lsb_first;
  logic soft_reset;
  logic checksum_fail;
  logic load_flag;
  logic [7:0] program_trigger;
  load_state_t load_state;
  load_state_t next_load_state;
  logic [7:0] nv_mem [NV_DEPTH];
  logic nv_host_we;
  logic [7:0] status_value;
  logic [7:0] next_rd_data;

  serial_link_port u_link (
    .sclk(sclk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe_n(sdio_oe_n),
    .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n),
    .serial_out_pin_select(serial_out_pin_select),
    .lsb_first(lsb_first),
    .wr_word(wr_word),
    .wr_tgl(wr_tgl),
    .rd_addr(rd_addr),
    .rd_tgl(rd_tgl),
    .rd_data(rd_data),
    .rd_ack_tgl(rd_ack_tgl)
  );

  // link toggles cross by two flops; the third flop only remembers the old value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_sync <= 3'b000;
      rd_sync <= 3'b000;
      fault_meta <= 5'h00;
      fault_sync <= 5'h00;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_tgl};
      fault_meta <= fault_code;
      fault_sync <= fault_meta;
    end
  end

  assign wr_ev = wr_sync[2] ^ wr_sync[1];
  assign rd_ev = rd_sync[2] ^ rd_sync[1];
  // the link word is stable for many serial clocks after its toggle
  assign wr_addr = wr_word.addr;
  assign wr_data = wr_word.data;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      soft_reset <= 1'b0;
    else
      soft_reset <= wr_ev && (wr_addr == OFS_INTERFACE_CONTROL) &&
        (wr_data[POS_CHIP_RESET_HI] || wr_data[POS_CHIP_RESET_LO]);
  end

  assign chip_reset = soft_reset;

  // interface control: mirrored pin-select and bit-order bits are stored once and read back on both positions
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_out_pin_select <= RST_SERIAL_OUT_PIN_SELECT;
      lsb_first <= RST_LSB_FIRST;
    end else if (soft_reset) begin
      serial_out_pin_select <= RST_SERIAL_OUT_PIN_SELECT;
      lsb_first <= RST_LSB_FIRST;
    end else if (wr_ev && wr_addr == OFS_INTERFACE_CONTROL) begin
      serial_out_pin_select <= wr_data[POS_SERIAL_OUT_HI] | wr_data[POS_SERIAL_OUT_LO];
      lsb_first <= wr_data[POS_LSB_FIRST_HI] | wr_data[POS_LSB_FIRST_LO];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      op_command <= RST_OPERATING_COMMAND;
    else if (soft_reset)
      op_command <= RST_OPERATING_COMMAND;
    else if (wr_ev && wr_addr == OFS_OPERATING_COMMAND)
      op_command <= wr_data;
  end

  // program trigger, host write wins over hardware clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      program_trigger <= RST_PROGRAM_TRIGGER;
      prog_start <= 1'b0;
    end else if (soft_reset) begin
      program_trigger <= RST_PROGRAM_TRIGGER;
      prog_start <= 1'b0;
    end else begin
      prog_start <= wr_ev && wr_addr == OFS_PROGRAM_TRIGGER &&
        wr_data == PROGRAM_START_VALUE && op_command == CMD_NV_PROGRAM_MODE;
      if (wr_ev && wr_addr == OFS_PROGRAM_TRIGGER)
        program_trigger <= wr_data;
      else if (prog_done)
        program_trigger <= RST_PROGRAM_TRIGGER;
    end
  end

  // load sequencer: runs after power-on and after every soft reset
  always_comb begin
    next_load_state = load_state;
    case (load_state)
      LD_START: next_load_state = LD_WAIT;
      LD_WAIT: if (load_done) next_load_state = LD_IDLE;
      LD_IDLE: next_load_state = LD_IDLE;
      default: next_load_state = LD_START;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      load_state <= LD_START;
    else if (soft_reset)
      load_state <= LD_START;
    else
      load_state <= next_load_state;
  end

  assign load_start = (load_state == LD_START);

  // checksum flag, held until the next load
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      checksum_fail <= RST_CHECKSUM_FAIL;
    else if (soft_reset)
      checksum_fail <= RST_CHECKSUM_FAIL;
    else if (load_state == LD_WAIT && load_done && load_crc_err)
      checksum_fail <= 1'b1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      load_flag <= RST_LOAD_DONE;
    else if (soft_reset)
      load_flag <= RST_LOAD_DONE;
    else if (load_state == LD_WAIT && load_done)
      load_flag <= 1'b1;
  end

  assign nv_host_we = wr_ev && wr_addr[7:5] == NV_WINDOW_TAG &&
    op_command == CMD_COMMAND_MODE;

  // nonvolatile shadow in the shared map
  generate
    for (genvar i = 0; i < NV_DEPTH; i++) begin : g_nv
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
          nv_mem[i] <= RST_NV_ENTRY;
        else if (soft_reset)
          nv_mem[i] <= RST_NV_ENTRY;
        else if (load_state == LD_WAIT && ld_we && ld_index == 5'(i))
          nv_mem[i] <= ld_data;
        else if (nv_host_we && wr_addr[4:0] == 5'(i))
          nv_mem[i] <= wr_data;
      end
    end
  endgenerate

  // bits that a failed checksum must not let through
  function automatic logic [7:0] forced_clear(input logic [4:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == NV_IDX_SYS_CONFIG1) begin
      m[POS_ONE_WIRE_DUAL_PORT] = 1'b1;
      m[POS_ONE_WIRE_ENTRY_WINDOW] = 1'b1;
      m[POS_ONE_WIRE_DISABLE] = 1'b1;
    end
    if (idx == NV_IDX_SYS_CONFIG2) begin
      m[POS_REGULATOR_DISABLE] = 1'b1;
      m[POS_REFERENCE_BUFFER_DISABLE] = 1'b1;
    end
    if (idx == NV_IDX_LOCK)
      m[POS_NV_LOCK] = 1'b1;
    return m;
  endfunction

  function automatic logic [7:0] nv_view(input logic [7:0] raw, input logic [4:0] idx,
                                         input logic fail);
    return fail ? (raw & ~forced_clear(idx)) : raw;
  endfunction

  // the forcing is applied on the way out so the stored image survives for diagnosis
  always_comb begin
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] lk;
    c1 = nv_view(nv_mem[NV_IDX_SYS_CONFIG1], NV_IDX_SYS_CONFIG1, checksum_fail);
    c2 = nv_view(nv_mem[NV_IDX_SYS_CONFIG2], NV_IDX_SYS_CONFIG2, checksum_fail);
    lk = nv_view(nv_mem[NV_IDX_LOCK], NV_IDX_LOCK, checksum_fail);
    safety_cfg.one_wire_disable = c1[POS_ONE_WIRE_DISABLE];
    safety_cfg.one_wire_dual_port = c1[POS_ONE_WIRE_DUAL_PORT];
    safety_cfg.one_wire_entry_window = c1[POS_ONE_WIRE_ENTRY_WINDOW];
    safety_cfg.regulator_disable = c2[POS_REGULATOR_DISABLE];
    safety_cfg.reference_buffer_disable = c2[POS_REFERENCE_BUFFER_DISABLE];
    safety_cfg.nv_lock = lk[POS_NV_LOCK];
  end

  always_comb begin
    status_value = 8'h00;
    status_value[7:POS_FAULT_CODE_LO] = fault_sync;
    status_value[POS_CHECKSUM_FAIL] = checksum_fail;
    status_value[POS_LOAD_DONE] = load_flag;
  end

  // status has no write path; reset bits always read 0
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_addr == OFS_INTERFACE_CONTROL) begin
      next_rd_data[POS_SERIAL_OUT_HI] = serial_out_pin_select;
      next_rd_data[POS_SERIAL_OUT_LO] = serial_out_pin_select;
      next_rd_data[POS_LSB_FIRST_HI] = lsb_first;
      next_rd_data[POS_LSB_FIRST_LO] = lsb_first;
    end else if (rd_addr == OFS_DEVICE_STATUS) begin
      next_rd_data = status_value;
    end else if (rd_addr == OFS_OPERATING_COMMAND) begin
      next_rd_data = op_command;
    end else if (rd_addr == OFS_PROGRAM_TRIGGER) begin
      next_rd_data = program_trigger;
    end else if (rd_addr[7:5] == NV_WINDOW_TAG) begin
      next_rd_data = nv_view(nv_mem[rd_addr[4:0]], rd_addr[4:0], checksum_fail);
    end
  end

  // answer is captured once and held, so the link may sample it at any later edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
      rd_ack_tgl <= 1'b0;
    end else if (rd_ev) begin
      rd_data <= next_rd_data;
      rd_ack_tgl <= ~rd_ack_tgl;
    end
  end

endmodule

/* File: bench/sensor_conditioner_regs_sva.sv */
module regs_checker
  import cond_regs_pkg::*;
(
  input wire logic clock, // register clock
  input wire logic nrst, // async reset, active low
  input wire logic cs_n, // chip select
  input wire logic sdio_oe_n, // shared pin enable
  input wire logic sdo_oe_n, // separate out enable
  input wire logic load_start, // load request
  input wire logic load_done, // load finished
  input wire logic load_crc_err, // load checksum mismatch
  input wire logic prog_start, // programming pulse
  input wire logic chip_reset, // soft reset pulse
  input wire logic [7:0] op_command, // command register
  input wire safety_cfg_t safety_cfg // effective safety bits
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic crc_seen;
  // a failed load keeps its forcing until the next reset reloads
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      crc_seen <= 1'b0;
    end else if (chip_reset) begin
      crc_seen <= 1'b0;
    end else if (load_done && load_crc_err) begin
      crc_seen <= 1'b1;
    end
  end
  a_prog_mode: assert property (prog_start |-> op_command == CMD_NV_PROGRAM_MODE)
    else $error("programming started outside program mode");
  a_prog_single: assert property (prog_start |=> !prog_start)
    else $error("programming pulse too long");
  a_reset_reload: assert property (chip_reset |-> ##[1:3] load_start)
    else $error("soft reset did not restart the load");
  a_reset_command: assert property (chip_reset |-> ##[1:2] op_command == 8'h03)
    else $error("soft reset left command register set");
  a_reset_ends: assert property (chip_reset |=> !chip_reset [*8])
    else $error("soft reset request did not clear");
  a_load_single: assert property (load_start |=> !load_start)
    else $error("load request held too long");
  a_oe_exclusive: assert property (sdio_oe_n || sdo_oe_n)
    else $error("both data outputs driven");
  a_oe_released: assert property (cs_n |-> sdio_oe_n && sdo_oe_n)
    else $error("data output driven while deselected");
  a_safety_forced: assert property (crc_seen |-> safety_cfg == '0)
    else $error("safety bits not forced after checksum failure");
  c_soft_reset: cover property (chip_reset);
  c_program: cover property (prog_start);
  c_crc_load: cover property (load_done && load_crc_err);
  c_shared_read: cover property (!sdio_oe_n);
endmodule

bind sensor_conditioner_regs regs_checker u_chk (.clock, .nrst, .cs_n, .sdio_oe_n, .sdo_oe_n,
  .load_start, .load_done, .load_crc_err, .prog_start, .chip_reset, .op_command, .safety_cfg);

/* File: bench/spi_host_model.sv */
module spi_host_model
  import cond_regs_pkg::*;
(
  output logic sclk, // serial clock, still between frames
  output logic cs_n, // chip select
  output logic sdi, // four-wire data in
  output wire logic sdio_i, // resolved shared pin
  input wire logic sdio_o, // device side of shared pin
  input wire logic sdio_oe_n, // device drives shared pin when low
  input wire logic sdo_o, // separate data out
  input wire logic sdo_oe_n, // separate out enable
  output logic done, // pulse after each read
  output logic [8:0] rd_word // enable fault flag and byte read
);
  timeunit 1ns;
  timeprecision 100ps;
  logic h_io = 1'b1;
  assign sdio_i = sdio_oe_n ? h_io : sdio_o;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    done = 1'b0;
    rd_word = '0;
    // deselect as a real rising edge, so the frame counter is cleared before the first frame
    #1 cs_n = 1'b1;
  end
  task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input logic fw, input logic lsb);
    logic [23:0] out;
    logic [7:0] got;
    logic bad;
    out = {rd, 7'h00, a, d};
    got = '0;
    bad = 1'b0;
    cs_n = 1'b0;
    for (int k = 0; k < (rd ? 32 : 24); k++) begin
      if (k < 24) begin
        sdi = out[(2 - k / 8) * 8 + (lsb ? k % 8 : 7 - k % 8)];
        h_io = sdi;
      end else begin
        // released lines toggle so a missing driver never reads as a match
        sdi = ~sdi;
        h_io = ~h_io;
        got[lsb ? k - 24 : 31 - k] = fw ? sdo_o : sdio_i;
        bad |= fw ? (sdo_oe_n || !sdio_oe_n) : (sdio_oe_n || !sdo_oe_n);
      end
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    sdi = ~sdi;
    h_io = ~h_io;
    if (rd) begin
      rd_word = {bad, got};
      done = 1'b1;
      #1 done = 1'b0;
    end
    #30;
  endtask
endmodule

/* File: bench/sensor_conditioner_regs_test.sv */
module sensor_conditioner_regs_test import cond_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, nrst, sclk, cs_n, sdi, sdio_i, sdio_o, sdio_oe_n, sdo_o, sdo_oe_n;
  logic [4:0] fault_code = '0, ld_index = '0;
  logic ld_we = 1'b0, load_done = 1'b0, load_crc_err = 1'b0, prog_done = 1'b0;
  logic load_start, prog_start, chip_reset, host_done, crc_mode = 1'b0, fw = 1'b1, lsb = 1'b0;
  logic [7:0] ld_data = '0, op_command, r;
  logic [8:0] rd_word;
  logic [31:0] lfsr = 32'h0c03_5a10;
  safety_cfg_t safety_cfg;
  logic [8:0] exp_q[$];
  int n_errors = 0, checks_done = 0;
  sensor_conditioner_regs u_dut (.clock, .nrst, .sclk, .cs_n, .sdi, .sdio_i, .sdio_o,
    .sdio_oe_n, .sdo_o, .sdo_oe_n, .fault_code, .load_start, .ld_we, .ld_index, .ld_data,
    .load_done, .load_crc_err, .prog_start, .prog_done, .chip_reset, .op_command, .safety_cfg);
  spi_host_model u_host (.sclk, .cs_n, .sdi, .sdio_i, .sdio_o, .sdio_oe_n, .sdo_o, .sdo_oe_n,
    .done(host_done), .rd_word);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_pulse(input logic sel);
    int k;
    k = 0;
    while ((sel ? chip_reset : prog_start) !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk(9'(k == 100), 9'h000);
    if (k == 100) wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.frame(1'b0, a, d, fw, lsb);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    u_host.frame(1'b1, a, 8'h00, fw, lsb);
  endtask
  always @(posedge host_done) begin
    chk(rd_word, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end
  // loader stand-in: fills entries 1, 2 and 31 with all ones after each load request
  initial begin
    forever begin
      @(negedge clock iff load_start);
      @(negedge clock iff !load_start);
      for (int i = 0; i < 3; i++) begin
        ld_we = 1'b1;
        ld_index = i == 2 ? NV_IDX_LOCK : 5'(i + 1);
        ld_data = 8'hff;
        @(negedge clock);
      end
      ld_we = 1'b0;
      load_done = 1'b1;
      load_crc_err = crc_mode;
      @(negedge clock);
      load_done = 1'b0;
      load_crc_err = 1'b0;
    end
  end
  initial begin
    #100us;
    chk(9'h001, 9'h000);
    wrap_up();
  end
  initial begin
    // a real falling edge, so link flops that see no serial clock yet are still reset
    nrst = 1'b1;
    #1 nrst = 1'b0;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (40) @(negedge clock);
    rd(OFS_INTERFACE_CONTROL, 8'h81);
    rd(OFS_OPERATING_COMMAND, RST_OPERATING_COMMAND);
    rd(OFS_PROGRAM_TRIGGER, RST_PROGRAM_TRIGGER);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      @(negedge clock);
      fault_code = i < 5 ? 5'(1 << i) : r[4:0];
      repeat (4) @(negedge clock);
      wr(OFS_DEVICE_STATUS, ~r);
      rd(OFS_DEVICE_STATUS, {fault_code, 3'b010});
    end
    $display("test reset and status finished");
    r = rnd();
    wr(8'ha1, r);
    rd(8'ha1, 8'hff);
    wr(OFS_OPERATING_COMMAND, CMD_COMMAND_MODE);
    wr(8'ha1, r);
    rd(8'ha1, r);
    rd(OFS_OPERATING_COMMAND, CMD_COMMAND_MODE);
    chk(9'(safety_cfg), {3'b000, r[1], r[3], r[2], 3'b111});
    $display("test command mode gate finished");
    wr(OFS_OPERATING_COMMAND, CMD_NV_PROGRAM_MODE);
    fork
      wait_pulse(1'b0);
      wr(OFS_PROGRAM_TRIGGER, PROGRAM_START_VALUE);
    join
    rd(OFS_PROGRAM_TRIGGER, PROGRAM_START_VALUE);
    repeat (20) @(negedge clock);
    prog_done = 1'b1;
    @(negedge clock);
    prog_done = 1'b0;
    rd(OFS_PROGRAM_TRIGGER, 8'h00);
    $display("test programming finished");
    wr(OFS_INTERFACE_CONTROL, 8'h42);
    fw = 1'b0;
    lsb = 1'b1;
    wr(8'hff, 8'h00);
    rd(OFS_INTERFACE_CONTROL, 8'h42);
    wr(OFS_INTERFACE_CONTROL, 8'h02);
    rd(OFS_INTERFACE_CONTROL, 8'h42);
    rd(8'ha1, r);
    $display("test bit order finished");
    for (int i = 0; i < 2; i++) begin
      crc_mode = (i == 0);
      fork
        wait_pulse(1'b1);
        wr(OFS_INTERFACE_CONTROL, i == 0 ? 8'h20 : 8'h04);
      join
      fw = 1'b1;
      lsb = 1'b0;
      repeat (40) @(negedge clock);
      wr(8'hff, 8'h00);
      rd(OFS_INTERFACE_CONTROL, 8'h81);
      rd(OFS_OPERATING_COMMAND, RST_OPERATING_COMMAND);
      rd(OFS_DEVICE_STATUS, {fault_code, i == 0, 2'b10});
      rd(8'ha1, i == 0 ? 8'hf1 : 8'hff);
      rd(8'ha2, i == 0 ? 8'h5f : 8'hff);
      rd(8'hbf, i == 0 ? 8'hfe : 8'hff);
      chk(9'(safety_cfg), i == 0 ? 9'h000 : 9'h03f);
    end
    $display("test soft reset finished");
    wrap_up();
  end
endmodule
